// file: flow_filt_pkg.sv
// constants, tables and state types for the flow output averaging filter
package flow_filt_pkg;
    localparam int SAMPLE_W = 16;
    localparam int SUM_W = 21;
    localparam int MAX_TAPS = 32;
    localparam int TAP_IDX_W = 5;
    localparam int FILL_W = 6;
    localparam int CODE_W = 3;
    localparam int COUNT_W = 6;
    localparam int RESP_W = 13;
    localparam int TMR_W = 27;
    localparam int DISP_DIV_W = 3;
    // filter size is held as log2 of the sample count: 1..5 means 2..32 samples
    localparam logic [CODE_W-1:0] SIZE_CODE_MIN = 3'h1;
    localparam logic [CODE_W-1:0] SIZE_CODE_MAX = 3'h5;
    localparam logic [CODE_W-1:0] SIZE_CODE_DEFAULT = 3'h3;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 6'h01;
    localparam logic [FILL_W-1:0] FILL_ONE = 6'h01;
    localparam logic [DISP_DIV_W-1:0] DISP_DIV_LAST = 3'h7;
    // 63% step response per size, in ms
    localparam logic [RESP_W-1:0] RESP_MS_2 = 13'h0384;
    localparam logic [RESP_W-1:0] RESP_MS_4 = 13'h0578;
    localparam logic [RESP_W-1:0] RESP_MS_8 = 13'h08fc;
    localparam logic [RESP_W-1:0] RESP_MS_16 = 13'h0fa0;
    localparam logic [RESP_W-1:0] RESP_MS_32 = 13'h1d4c;
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int IDLE_TIME_MS = 5000;
    localparam int REPEAT_TIME_MS = 250;
    localparam int IDLE_CYCLES_DEF = IDLE_TIME_MS * CLK_FREQ_KHZ;
    localparam int REPEAT_CYCLES_DEF = REPEAT_TIME_MS * CLK_FREQ_KHZ;

    typedef enum logic [2:0] {
        MENU_RUN = 3'b000,
        MENU_FLOW_BANNER = 3'b001,
        MENU_MODE_CODE = 3'b010,
        MENU_FILT_BANNER = 3'b011,
        MENU_FILT_VALUE = 3'b100
    } menu_state_e;

    typedef enum logic [2:0] {
        DISP_FLOW = 3'b000,
        DISP_FLOW_BANNER = 3'b001,
        DISP_PULSE_MODE_CODE = 3'b010,
        DISP_ALARM_MODE_CODE = 3'b011,
        DISP_FILTER_MENU_BANNER = 3'b100,
        DISP_FILTER_VALUE = 3'b101
    } disp_code_e;
endpackage

// file: flow_avg_core.sv
// running average over the last 2**size_code samples, refilled after clear
`timescale 1ns/1ps
module flow_avg_core (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic clear_in,
    input wire logic [flow_filt_pkg::CODE_W-1:0] size_code_in,
    input wire logic [flow_filt_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic [flow_filt_pkg::SAMPLE_W-1:0] avg_out,
    output logic avg_valid_out
);
    import flow_filt_pkg::*;

    logic [SAMPLE_W-1:0] tap_r [MAX_TAPS];
    logic [SAMPLE_W-1:0] tap_nxt [MAX_TAPS];
    logic [SUM_W-1:0] sum_r, sum_nxt;
    logic [FILL_W-1:0] fill_r, fill_nxt, taps_n;
    logic [SAMPLE_W-1:0] avg_nxt, oldest;
    logic avg_valid_nxt, full, full_after;

    genvar gi;
    generate
        for (gi = 0; gi < MAX_TAPS; gi++) begin : g_tap
            if (gi == 0) begin : g_first
                assign tap_nxt[gi] = sample_valid_in ? sample_in : tap_r[gi];
            end else begin : g_rest
                assign tap_nxt[gi] = sample_valid_in ? tap_r[gi-1] : tap_r[gi];
            end
            always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    tap_r[gi] <= '0;
                end else begin
                    tap_r[gi] <= tap_nxt[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        taps_n = FILL_ONE << size_code_in;
        oldest = tap_r[TAP_IDX_W'(taps_n - FILL_ONE)];
        full = (fill_r == taps_n);
        full_after = full || ((fill_r + FILL_ONE) == taps_n);
        sum_nxt = sum_r;
        fill_nxt = fill_r;
        avg_nxt = avg_out;
        avg_valid_nxt = 1'b0;
        if (clear_in) begin
            sum_nxt = '0;
            fill_nxt = '0;
        end else if (sample_valid_in) begin
            sum_nxt = sum_r + SUM_W'(sample_in) - (full ? SUM_W'(oldest) : '0);
            if (!full) begin
                fill_nxt = fill_r + FILL_ONE;
            end
            if (full_after) begin
                avg_nxt = SAMPLE_W'(sum_nxt >> size_code_in);
                avg_valid_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sum_r <= '0;
            fill_r <= '0;
            avg_out <= '0;
            avg_valid_out <= 1'b0;
        end else begin
            sum_r <= sum_nxt;
            fill_r <= fill_nxt;
            avg_out <= avg_nxt;
            avg_valid_out <= avg_valid_nxt;
        end
    end

    a_clear_empties: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        clear_in |=> fill_r == '0 && sum_r == '0 && !avg_valid_out)
        else $error("clear did not empty the averager");
    a_no_early_avg: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (!sample_valid_in || clear_in || !full_after) |=> !avg_valid_out)
        else $error("average given before window filled");
    a_avg_scaled: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        avg_valid_out |-> avg_out == SAMPLE_W'(sum_r >> $past(size_code_in)))
        else $error("average is not sum over window size");
endmodule // flow_avg_core

// file: flow_filter_cfg.sv
// flow output averaging filter with push-button filter size menu
//
// Summary of operation
// - analog output is the average of 2, 4, 8, 16 or 32 samples.
// - step response per size: 0.9, 1.4, 2.3, 4 and 7.5 seconds.
// - filter feeds the current-loop value; display refreshes slower.
// - holding menu in flow view shows flow banner, then relay mode code.
// - idle five seconds on mode code shows the filter menu banner.
// - set on filter banner shows stored sample count with F prefix.
// - each menu press advances the value; holding menu scrolls continuously.
// - set on a shown value stores it and restarts the device.
// - default filter size is eight samples.
// - five idle seconds in the filter menu return to run without storing.
`timescale 1ns/1ps
module flow_filter_cfg #(
    parameter int IDLE_CYCLES = flow_filt_pkg::IDLE_CYCLES_DEF,
    parameter int REPEAT_CYCLES = flow_filt_pkg::REPEAT_CYCLES_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic menu_btn_in,
    input wire logic set_btn_in,
    input wire logic flow_view_in,
    input wire logic pulse_mode_in,
    input wire logic [flow_filt_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic [flow_filt_pkg::SAMPLE_W-1:0] dac_value_out,
    output logic dac_valid_out,
    output logic [flow_filt_pkg::SAMPLE_W-1:0] display_flow_out,
    output flow_filt_pkg::disp_code_e disp_code_out,
    output logic [flow_filt_pkg::COUNT_W-1:0] filter_count_out,
    output logic [flow_filt_pkg::CODE_W-1:0] size_code_out,
    output logic [flow_filt_pkg::RESP_W-1:0] resp_time_ms_out,
    output logic restart_out
);
    import flow_filt_pkg::*;

    localparam logic [TMR_W-1:0] IDLE_LAST = TMR_W'(IDLE_CYCLES - 1);
    localparam logic [TMR_W-1:0] REPEAT_LAST = TMR_W'(REPEAT_CYCLES - 1);
    localparam logic [TMR_W-1:0] TMR_ONE = 27'h0000001;

    menu_state_e state_r, state_nxt;
    disp_code_e disp_nxt;
    logic menu_q_r, set_q_r;
    logic [TMR_W-1:0] idle_r, idle_nxt, rep_r, rep_nxt;
    logic [CODE_W-1:0] pend_r, pend_nxt, size_nxt;
    logic restart_nxt, menu_rise, set_rise, active, timeout, advance;
    logic [COUNT_W-1:0] count_nxt;
    logic [RESP_W-1:0] resp_nxt;
    logic [DISP_DIV_W-1:0] div_r, div_nxt;
    logic [SAMPLE_W-1:0] avg, disp_flow_nxt;
    logic avg_valid;

    flow_avg_core u_avg (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .clear_in(restart_out),
        .size_code_in(size_code_out),
        .sample_in(sample_in),
        .sample_valid_in(sample_valid_in),
        .avg_out(avg),
        .avg_valid_out(avg_valid)
    );

    // menu sequencer
    always_comb begin
        menu_rise = menu_btn_in && !menu_q_r;
        set_rise = set_btn_in && !set_q_r;
        active = menu_btn_in || set_btn_in;
        timeout = !active && (idle_r == IDLE_LAST);
        state_nxt = state_r;
        pend_nxt = pend_r;
        size_nxt = size_code_out;
        restart_nxt = 1'b0;
        rep_nxt = '0;
        advance = 1'b0;
        if (state_r == MENU_FILT_VALUE && menu_btn_in) begin
            if (menu_rise) begin
                advance = 1'b1;
            end else if (rep_r == REPEAT_LAST) begin
                advance = 1'b1;
            end else begin
                rep_nxt = rep_r + TMR_ONE;
            end
        end
        case (state_r)
            MENU_RUN: begin
                if (menu_btn_in && flow_view_in) begin
                    state_nxt = MENU_FLOW_BANNER;
                end
            end
            MENU_FLOW_BANNER: begin
                if (!menu_btn_in) begin
                    state_nxt = MENU_MODE_CODE;
                end
            end
            MENU_MODE_CODE: begin
                // relay set-up is handled elsewhere; leave the filter path
                if (menu_rise || set_rise) begin
                    state_nxt = MENU_RUN;
                end else if (timeout) begin
                    state_nxt = MENU_FILT_BANNER;
                end
            end
            MENU_FILT_BANNER: begin
                if (set_rise) begin
                    state_nxt = MENU_FILT_VALUE;
                    pend_nxt = size_code_out;
                end else if (timeout) begin
                    state_nxt = MENU_RUN;
                end
            end
            MENU_FILT_VALUE: begin
                if (set_rise) begin
                    size_nxt = pend_r;
                    restart_nxt = 1'b1;
                    state_nxt = MENU_RUN;
                end else if (advance) begin
                    pend_nxt = (pend_r == SIZE_CODE_MAX) ? SIZE_CODE_MIN : pend_r + 3'h1;
                end else if (timeout) begin
                    state_nxt = MENU_RUN;
                end
            end
            default: begin
                state_nxt = MENU_RUN;
            end
        endcase
        if (active || state_nxt != state_r) begin
            idle_nxt = '0;
        end else if (idle_r == IDLE_LAST) begin
            idle_nxt = idle_r;
        end else begin
            idle_nxt = idle_r + TMR_ONE;
        end
        case (state_nxt)
            MENU_FLOW_BANNER: disp_nxt = DISP_FLOW_BANNER;
            MENU_MODE_CODE: disp_nxt = pulse_mode_in ? DISP_PULSE_MODE_CODE : DISP_ALARM_MODE_CODE;
            MENU_FILT_BANNER: disp_nxt = DISP_FILTER_MENU_BANNER;
            MENU_FILT_VALUE: disp_nxt = DISP_FILTER_VALUE;
            default: disp_nxt = DISP_FLOW;
        endcase
        count_nxt = COUNT_ONE << ((state_nxt == MENU_FILT_VALUE) ? pend_nxt : size_nxt);
        case (size_code_out)
            3'h1: resp_nxt = RESP_MS_2;
            3'h2: resp_nxt = RESP_MS_4;
            3'h3: resp_nxt = RESP_MS_8;
            3'h4: resp_nxt = RESP_MS_16;
            3'h5: resp_nxt = RESP_MS_32;
            default: resp_nxt = RESP_MS_8;
        endcase
    end

    // display takes one of every eight averages
    always_comb begin
        div_nxt = div_r;
        disp_flow_nxt = display_flow_out;
        if (restart_out) begin
            div_nxt = '0;
        end else if (avg_valid) begin
            div_nxt = div_r + 3'h1;
            if (div_r == DISP_DIV_LAST) begin
                disp_flow_nxt = avg;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= MENU_RUN;
            menu_q_r <= 1'b0;
            set_q_r <= 1'b0;
            idle_r <= '0;
            rep_r <= '0;
            pend_r <= SIZE_CODE_DEFAULT;
            size_code_out <= SIZE_CODE_DEFAULT;
            restart_out <= 1'b0;
            disp_code_out <= DISP_FLOW;
            filter_count_out <= COUNT_ONE << SIZE_CODE_DEFAULT;
            resp_time_ms_out <= RESP_MS_8;
            div_r <= '0;
            display_flow_out <= '0;
            dac_value_out <= '0;
            dac_valid_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            menu_q_r <= menu_btn_in;
            set_q_r <= set_btn_in;
            idle_r <= idle_nxt;
            rep_r <= rep_nxt;
            pend_r <= pend_nxt;
            size_code_out <= size_nxt;
            restart_out <= restart_nxt;
            disp_code_out <= disp_nxt;
            filter_count_out <= count_nxt;
            resp_time_ms_out <= resp_nxt;
            div_r <= div_nxt;
            display_flow_out <= disp_flow_nxt;
            dac_value_out <= avg;
            dac_valid_out <= avg_valid && !restart_out;
        end
    end

    sequence s_release_banner;
        state_r == MENU_FLOW_BANNER && !menu_btn_in;
    endsequence
    sequence s_store_press;
        state_r == MENU_FILT_VALUE && set_rise;
    endsequence

    a_mode_code_shown: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_release_banner |=> disp_code_out == ($past(pulse_mode_in) ? DISP_PULSE_MODE_CODE : DISP_ALARM_MODE_CODE))
        else $error("relay mode code not shown after release");
    a_flow_banner: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        state_r == MENU_RUN && menu_btn_in && flow_view_in |=> disp_code_out == DISP_FLOW_BANNER)
        else $error("flow banner not shown while menu held");
    a_banner_timeout: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        state_r == MENU_MODE_CODE && timeout |=> disp_code_out == DISP_FILTER_MENU_BANNER)
        else $error("filter banner not shown after idle");
    a_value_shown: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        state_r == MENU_FILT_BANNER && set_rise
        |=> disp_code_out == DISP_FILTER_VALUE && filter_count_out == (COUNT_ONE << size_code_out))
        else $error("stored filter count not shown");
    a_store_restart: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        s_store_press |=> restart_out && size_code_out == $past(pend_r) ##1 !restart_out && state_r == MENU_RUN)
        else $error("store did not restart once with new size");
    a_size_wraps: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        state_r == MENU_FILT_VALUE && advance && !set_rise && pend_r == SIZE_CODE_MAX
        |=> pend_r == SIZE_CODE_MIN)
        else $error("filter value did not wrap to smallest");
    a_idle_exit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        state_r == MENU_FILT_VALUE && timeout |=> state_r == MENU_RUN && !restart_out && $stable(size_code_out))
        else $error("idle menu exit stored a value");
    a_resp_default: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        size_code_out == SIZE_CODE_DEFAULT && $stable(size_code_out) |-> resp_time_ms_out == RESP_MS_8)
        else $error("response time does not match size");
    a_display_slow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !(avg_valid && div_r == DISP_DIV_LAST) |=> $stable(display_flow_out))
        else $error("display refreshed at output rate");
endmodule // flow_filter_cfg

// file: flow_operator.sv
// behavioural front-panel operator driving the menu and set buttons
`timescale 1ns/1ps
module flow_operator (
    input wire logic clk_sys_in,
    output logic menu_btn_out,
    output logic set_btn_out
);
    initial begin
        menu_btn_out = 1'b0;
        set_btn_out = 1'b0;
    end
    // buttons change only just after a rising edge, as a synchronous level
    task automatic drive(input logic menu, input logic set);
        @(posedge clk_sys_in);
        menu_btn_out <= menu;
        set_btn_out <= set;
    endtask
endmodule // flow_operator

// file: tb.sv
// self-checking bench for the flow output averaging filter and its menu
`timescale 1ns/1ps
module tb;
    import flow_filt_pkg::*;
    localparam int IDLE = 40;
    localparam int REP = 8;
    logic clk_sys_in;
    logic rst_b_in;
    logic menu_btn;
    logic set_btn;
    logic flow_view;
    logic pulse_mode;
    logic [SAMPLE_W-1:0] sample;
    logic sample_valid;
    logic [SAMPLE_W-1:0] dac_value;
    logic dac_valid;
    logic [SAMPLE_W-1:0] display_flow;
    disp_code_e disp_code;
    logic [COUNT_W-1:0] filter_count;
    logic [CODE_W-1:0] size_code;
    logic [RESP_W-1:0] resp_ms;
    logic restart;
    int err_count = 0;
    int n_compared = 0;
    int dac_n = 0;
    int restart_n = 0;
    logic [SAMPLE_W-1:0] dac_last;
    int stored = 3;
    logic [RESP_W-1:0] resp_tab [1:5] = '{13'h0384, 13'h0578, 13'h08fc, 13'h0fa0, 13'h1d4c};

    flow_operator flow_operator_inst (.clk_sys_in(clk_sys_in), .menu_btn_out(menu_btn),
        .set_btn_out(set_btn));
    flow_filter_cfg #(.IDLE_CYCLES(IDLE), .REPEAT_CYCLES(REP)) flow_filter_cfg_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .menu_btn_in(menu_btn),
        .set_btn_in(set_btn), .flow_view_in(flow_view), .pulse_mode_in(pulse_mode),
        .sample_in(sample), .sample_valid_in(sample_valid), .dac_value_out(dac_value),
        .dac_valid_out(dac_valid), .display_flow_out(display_flow),
        .disp_code_out(disp_code), .filter_count_out(filter_count),
        .size_code_out(size_code), .resp_time_ms_out(resp_ms), .restart_out(restart));

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        if (dac_valid === 1'b1) begin
            dac_n <= dac_n + 1;
            dac_last <= dac_value;
        end
        if (restart === 1'b1) restart_n <= restart_n + 1;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_disp(input disp_code_e code, input int limit);
        int i;
        i = 0;
        while (disp_code !== code && i < limit) begin
            @(posedge clk_sys_in);
            i++;
        end
        check("disp_code", disp_code, code);
    endtask

    task automatic send(input int base, input int step, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_in);
            sample <= SAMPLE_W'(base + i * step);
            sample_valid <= 1'b1;
        end
        @(posedge clk_sys_in);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask

    // hold menu, release, idle to the filter banner, set to reach the value view
    task automatic to_value(input disp_code_e mode);
        flow_operator_inst.drive(1'b1, 1'b0);
        repeat (3) @(posedge clk_sys_in);
        check("flow banner", disp_code, DISP_FLOW_BANNER);
        flow_operator_inst.drive(1'b0, 1'b0);
        wait_disp(mode, 5);
        wait_disp(DISP_FILTER_MENU_BANNER, IDLE + 10);
        flow_operator_inst.drive(1'b0, 1'b1);
        flow_operator_inst.drive(1'b0, 1'b0);
        wait_disp(DISP_FILTER_VALUE, 5);
        check("stored count", filter_count, 32'(1 << stored));
    endtask

    task automatic test_reset();
        check("size code", size_code, 3);
        check("count", filter_count, 8);
        check("resp ms", resp_ms, 2300);
        check("disp", disp_code, DISP_FLOW);
    endtask

    task automatic test_avg8();
        send(100, 100, 7);
        check("no early output", dac_n, 0);
        send(800, 100, 2);
        check("outputs", dac_n, 2);
        check("avg 200..900", dac_last, 550);
        check("display held", display_flow, 0);
        send(1000, 100, 6);
        check("eighth output", dac_n, 8);
        check("display 800..1500", display_flow, 1150);
    endtask

    task automatic test_no_view();
        flow_view <= 1'b0;
        flow_operator_inst.drive(1'b1, 1'b0);
        repeat (3) @(posedge clk_sys_in);
        check("menu outside flow view", disp_code, DISP_FLOW);
        flow_operator_inst.drive(1'b0, 1'b0);
        flow_view <= 1'b1;
        @(posedge clk_sys_in);
    endtask

    task automatic test_scroll();
        to_value(DISP_PULSE_MODE_CODE);
        flow_operator_inst.drive(1'b1, 1'b0);
        flow_operator_inst.drive(1'b0, 1'b0);
        @(posedge clk_sys_in);
        check("step", filter_count, 16);
        flow_operator_inst.drive(1'b1, 1'b0);
        repeat (REP + 3) @(posedge clk_sys_in);
        flow_operator_inst.drive(1'b0, 1'b0);
        @(posedge clk_sys_in);
        check("held scroll wraps", filter_count, 2);
        wait_disp(DISP_FLOW, IDLE + 10);
        check("not stored", size_code, 3);
        check("no restart", restart_n, 0);
    endtask

    task automatic set_size(input int code);
        int i;
        to_value(DISP_ALARM_MODE_CODE);
        i = 0;
        while (filter_count !== COUNT_W'(1 << code) && i < 6) begin
            flow_operator_inst.drive(1'b1, 1'b0);
            flow_operator_inst.drive(1'b0, 1'b0);
            @(posedge clk_sys_in);
            i++;
        end
        i = restart_n;
        flow_operator_inst.drive(1'b0, 1'b1);
        flow_operator_inst.drive(1'b0, 1'b0);
        repeat (3) @(posedge clk_sys_in);
        stored = code;
        check("restart pulse", restart_n, i + 1);
        check("size code", size_code, code);
        check("resp ms", resp_ms, resp_tab[code]);
        check("back to run", disp_code, DISP_FLOW);
    endtask

    task automatic test_sizes();
        int base;
        pulse_mode <= 1'b0;
        for (int c = 5; c >= 1; c--) set_size(c);
        base = dac_n;
        send(10, 20, 1);
        check("refill", dac_n - base, 0);
        send(30, 20, 1);
        check("refill out", dac_n - base, 1);
        check("avg of two", dac_last, 20);
    endtask

    initial begin
        rst_b_in = 1'b0;
        flow_view = 1'b1;
        pulse_mode = 1'b1;
        sample = '0;
        sample_valid = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        test_reset();
        test_avg8();
        test_no_view();
        test_scroll();
        test_sizes();
        print_verdict();
    end

    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule // tb
